// *** src/fspmc_top.sv ***
// Behaviour
// R1 - clear disable, set select, trap enters firmware
// R2 - trap goes to firmware only when selected
// R3 - firmware run NMI sets flag bit seven
// R4 - software clears NMI flag before each call
// R5 - NMI during handoff may be lost
// R6 - r6-r9 and ep in, r10 result out
// R7 - leave: unlock, write disable set, select clear
// R8 - wait 100 us before flash access
// R9 - interrupt between unlock and write drops it
// R10 - five nops after protected write
// R11 - unlock and write from same register
// R12 - no DMA for unlock or protected write
// R13 - disable reads 1 on flash, 0 mask ROM
// R14 - caller runs outside block 0 and flash
// R15 - mode bits: disable 3, voltage 2, select 1
// R16 - select takes effect only with voltage present
// R17 - disable bit blocks all flash write/erase
// R18 - unlock arms exactly one protected write
// R19 - mode register reads need no unlock
//
// Purpose: Flash self-programming mode control with an APB register file.
// Assumes: Single pclk domain at 200 MHz; pins are synchronised here.
// Notes: Zero-wait APB; read data is captured in the setup cycle.
`timescale 1ns/100ps
`include "fspmc_params.svh"
module fspmc_top #(
  parameter int SETTLE_CYC = `FSPMC_SETTLE_US * `FSPMC_CLK_MHZ,
  parameter bit FLASH_EQUIPPED = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vpp_pin,
  input wire logic nmi_pin,
  input wire logic int_accept,
  input wire logic trap_req,
  input wire logic [4:0] trap_vec,
  input wire logic fw_done,
  input wire logic [31:0] fw_result,
  output logic fw_enter,
  output logic fw_running,
  output logic app_trap,
  output logic [4:0] app_trap_vec,
  output logic nmi_req,
  output logic [32*`FSPMC_NUM_ARGS-1:0] fw_args,
  output logic flash_write_enable,
  output logic flash_access_ok
);
  localparam int SETTLE_LOAD = (SETTLE_CYC < 1) ? 1 : SETTLE_CYC;

  // Matches an address against a register offset.
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[`FSPMC_ADDR_W-1:0] == off) && (a[31:`FSPMC_ADDR_W] == 24'h000000);
  endfunction

  fspmc_unlock_if ul ();

  // Synchroniser stages for the two pins.
  logic vpp_meta;
  logic vpp_s;
  logic nmi_meta;
  logic nmi_s;
  logic nmi_prev;

  // Register state.
  logic wr_disable;
  logic sel;
  logic err_flag;
  logic nmi_flag;
  fspmc_pkg::fspmc_word_t arg_reg [`FSPMC_NUM_ARGS];
  fspmc_pkg::fspmc_word_t result_reg;
  logic [`FSPMC_SETTLE_W-1:0] settle_cnt;
  fspmc_pkg::fspmc_fw_state_e fw_state;
  fspmc_pkg::fspmc_fw_state_e next_fw_state;
  logic [2:0] handoff_cnt;

  // Bus decode.
  logic setup_ph;
  logic acc_ph;
  logic wr_acc;
  logic hit_mode;
  logic hit_cmd;
  logic hit_stat;
  logic hit_nmi;
  logic hit_res;
  logic [`FSPMC_NUM_ARGS-1:0] hit_arg;
  logic mapped;
  logic byte0_en;

  assign setup_ph = psel & ~penable;
  assign acc_ph = psel & penable;
  assign wr_acc = acc_ph & pwrite;
  assign byte0_en = pstrb[0];
  assign hit_mode = hit(paddr, `FSPMC_OFF_MODE);
  assign hit_cmd = hit(paddr, `FSPMC_OFF_CMD);
  assign hit_stat = hit(paddr, `FSPMC_OFF_STAT);
  assign hit_nmi = hit(paddr, `FSPMC_OFF_NMI);
  assign hit_res = hit(paddr, `FSPMC_OFF_RESULT);

  // Argument registers r6..r9 and ep sit at consecutive words.
  genvar gi;
  generate
    for (gi = 0; gi < `FSPMC_NUM_ARGS; gi++) begin : g_arg
      assign hit_arg[gi] = hit(paddr, 8'(`FSPMC_OFF_ARG0 + 4 * gi));
      assign fw_args[32*gi +: 32] = arg_reg[gi];
      // R6 firmware arguments
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          arg_reg[gi] <= `FSPMC_WORD_ZERO;
        end else if (ce && wr_acc && hit_arg[gi]) begin
          arg_reg[gi] <= pwdata;
        end
      end
    end
  endgenerate

  assign mapped = hit_mode | hit_cmd | hit_stat | hit_nmi | hit_res | (|hit_arg);

  // Access events for the unlock guard; a protected write needs byte 0.
  // R18 arm and disarm
  assign ul.cmd_wr = wr_acc & hit_cmd;
  assign ul.prot_wr = wr_acc & hit_mode & byte0_en;
  assign ul.other_acc = acc_ph & ~ul.cmd_wr & ~ul.prot_wr;
  // R9 interrupt between steps
  assign ul.int_ack = int_accept;

  fspmc_unlock u_unlock (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .ul(ul)
  );

  // Two-stage synchronisers for the voltage detect and NMI pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vpp_meta <= 1'b0;
      vpp_s <= 1'b0;
      nmi_meta <= 1'b0;
      nmi_s <= 1'b0;
      nmi_prev <= 1'b0;
    end else if (ce) begin
      vpp_meta <= vpp_pin;
      vpp_s <= vpp_meta;
      nmi_meta <= nmi_pin;
      nmi_s <= nmi_meta;
      nmi_prev <= nmi_s;
    end
  end

  logic nmi_edge;
  logic vpp_ok;
  logic mode_accept;
  logic leave_sp;
  logic fw_trap_hit;
  logic settle_busy;

  assign nmi_edge = nmi_s & ~nmi_prev;
  // R15 voltage bit read-only
  assign vpp_ok = vpp_s & FLASH_EQUIPPED;
  assign mode_accept = ul.accept;
  assign settle_busy = (settle_cnt != `FSPMC_SETTLE_W'(0));
  // Leaving self-programming starts the settle wait.
  assign leave_sp = mode_accept & sel & ~pwdata[`FSPMC_BIT_SEL];
  // R2 trap routing
  assign fw_trap_hit = trap_req & (trap_vec == `FSPMC_TRAP_FW_VEC) & sel &
    (fw_state == fspmc_pkg::FSPMC_FW_IDLE);

  // Mode register: only an armed write changes it; fixed bits stay zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_disable <= `FSPMC_DIS_RST & FLASH_EQUIPPED; // A mask ROM part resets to zero.
      sel <= 1'b0;
    end else if (ce && mode_accept) begin
      // R13 mask ROM reads zero
      wr_disable <= pwdata[`FSPMC_BIT_DIS] & FLASH_EQUIPPED;
      // R16 select needs voltage
      sel <= pwdata[`FSPMC_BIT_SEL] & vpp_ok;
    end
  end

  // Protection error: set on a refused write, cleared by writing one.
  // Set wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flag <= 1'b0;
    end else if (ce) begin
      // R18 refused write flags
      if (ul.refuse) begin
        err_flag <= 1'b1;
      end else if (wr_acc && hit_stat && byte0_en && pwdata[`FSPMC_BIT_ERR]) begin
        err_flag <= 1'b0;
      end
    end
  end

  // Firmware hand-off sequencer.
  always_comb begin
    next_fw_state = fw_state;
    case (fw_state)
      fspmc_pkg::FSPMC_FW_IDLE: begin
        // R1 trap enters firmware
        if (fw_trap_hit) begin
          next_fw_state = fspmc_pkg::FSPMC_FW_HANDOFF;
        end
      end
      fspmc_pkg::FSPMC_FW_HANDOFF: begin
        if (handoff_cnt == 3'h1) begin
          next_fw_state = fspmc_pkg::FSPMC_FW_RUN;
        end
      end
      fspmc_pkg::FSPMC_FW_RUN: begin
        if (fw_done) begin
          next_fw_state = fspmc_pkg::FSPMC_FW_IDLE;
        end
      end
      default: begin
        next_fw_state = fspmc_pkg::FSPMC_FW_IDLE;
      end
    endcase
  end

  // State, hand-off counter and result capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fw_state <= fspmc_pkg::FSPMC_FW_IDLE;
      handoff_cnt <= 3'h0;
      result_reg <= `FSPMC_WORD_ZERO;
    end else if (ce) begin
      fw_state <= next_fw_state;
      handoff_cnt <= fw_trap_hit ? `FSPMC_HANDOFF_CYC :
        ((handoff_cnt != 3'h0) ? handoff_cnt - 3'h1 : 3'h0);
      // R6 result in r10
      if (fw_state == fspmc_pkg::FSPMC_FW_RUN && fw_done) begin
        result_reg <= fw_result;
      end
    end
  end

  // NMI flag: set during a firmware run, never cleared by hardware.
  // Software clears it by writing zero to bit 7; a set in that cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_flag <= 1'b0;
    end else if (ce) begin
      // R3 NMI during run
      if (nmi_edge && fw_state == fspmc_pkg::FSPMC_FW_RUN) begin
        nmi_flag <= 1'b1;
      end else if (wr_acc && hit_nmi && byte0_en && !pwdata[`FSPMC_BIT_NMI]) begin
        // R4 software clears flag
        nmi_flag <= 1'b0;
      end
    end
  end

  // Trap and NMI outputs; an NMI in the hand-off window is swallowed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fw_enter <= 1'b0;
      app_trap <= 1'b0;
      app_trap_vec <= 5'h00;
      nmi_req <= 1'b0;
    end else if (ce) begin
      fw_enter <= fw_trap_hit;
      app_trap <= trap_req & ~fw_trap_hit;
      if (trap_req && !fw_trap_hit) begin
        app_trap_vec <= trap_vec;
      end
      // R5 handoff NMI lost
      nmi_req <= nmi_edge & (fw_state == fspmc_pkg::FSPMC_FW_IDLE) & ~fw_trap_hit;
    end
  end

  // Settle counter after returning to normal mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= `FSPMC_SETTLE_W'(0);
    end else if (ce) begin
      // R8 settle wait
      if (leave_sp) begin
        settle_cnt <= `FSPMC_SETTLE_W'(SETTLE_LOAD);
      end else if (settle_busy) begin
        settle_cnt <= settle_cnt - `FSPMC_SETTLE_W'(1);
      end
    end
  end

  // Flash controls seen by the array.
  // R17 disable blocks writing
  assign flash_write_enable = ~wr_disable & vpp_ok & sel;
  assign flash_access_ok = ~settle_busy & ~sel;
  assign fw_running = (fw_state == fspmc_pkg::FSPMC_FW_RUN);

  // Read mux; the mode register reads freely.
  logic [31:0] rd_mux;
  logic [31:0] rd_arg;
  logic [31:0] mode_val;
  logic [31:0] stat_val;
  logic [31:0] nmi_val;

  // R19 free mode read
  // R15 mode bit layout
  assign mode_val = {28'h0000000, wr_disable, vpp_ok, sel, 1'b0};
  assign stat_val = {29'h00000000, fw_running, settle_busy, err_flag};
  assign nmi_val = {24'h000000, nmi_flag, 7'h00};

  always_comb begin
    rd_arg = `FSPMC_WORD_ZERO;
    for (int i = 0; i < `FSPMC_NUM_ARGS; i++) begin
      if (hit_arg[i]) begin
        rd_arg = arg_reg[i];
      end
    end
  end

  assign rd_mux = hit_mode ? mode_val :
    hit_stat ? stat_val :
    hit_nmi ? nmi_val :
    hit_res ? result_reg :
    rd_arg;

  // Read data and error answer are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `FSPMC_WORD_ZERO;
      pslverr <= 1'b0;
    end else if (ce && setup_ph) begin
      prdata <= pwrite ? `FSPMC_WORD_ZERO : rd_mux;
      pslverr <= ~mapped;
    end
  end

  // Zero-wait slave; a frozen clock enable stalls the bus.
  assign pready = ce;
endmodule

// *** src/fspmc_params.svh ***
// Purpose: Named offsets, bit positions, reset values and timing figures.
// Assumes: Included by every design file that needs a number.
// Notes: Definitions only.
`ifndef FSPMC_PARAMS_SVH
`define FSPMC_PARAMS_SVH
`define FSPMC_ADDR_W 8
`define FSPMC_OFF_MODE 8'h00
`define FSPMC_OFF_CMD 8'h04
`define FSPMC_OFF_STAT 8'h08
`define FSPMC_OFF_NMI 8'h0C
`define FSPMC_OFF_ARG0 8'h10
`define FSPMC_OFF_RESULT 8'h24
`define FSPMC_NUM_ARGS 5
`define FSPMC_ARG_IDX_W 3
`define FSPMC_BIT_DIS 3
`define FSPMC_BIT_VPP 2
`define FSPMC_BIT_SEL 1
`define FSPMC_BIT_ERR 0
`define FSPMC_BIT_SETTLE 1
`define FSPMC_BIT_FW 2
`define FSPMC_BIT_NMI 7
`define FSPMC_DIS_RST 1'h1
`define FSPMC_TRAP_FW_VEC 5'h1F
`define FSPMC_HANDOFF_CYC 3'h4
`define FSPMC_SETTLE_US 100
`define FSPMC_CLK_MHZ 200
`define FSPMC_SETTLE_W 16
`define FSPMC_WORD_ZERO 32'h0000_0000
`endif

// *** src/fspmc_pkg.sv ***
// Purpose: Types shared by the mode-control design files.
// Assumes: Constants live in fspmc_params.svh.
// Notes: Nothing is imported; users write fspmc_pkg::name.
package fspmc_pkg;
  typedef enum logic [2:0] {
    FSPMC_FW_IDLE = 3'h1,
    FSPMC_FW_HANDOFF = 3'h2,
    FSPMC_FW_RUN = 3'h4
  } fspmc_fw_state_e;
  typedef logic [31:0] fspmc_word_t;
endpackage

// *** src/fspmc_unlock_if.sv ***
// Purpose: Carries access events to the unlock guard and its verdict back.
// Assumes: All signals are on pclk.
// Notes: One modport for each side.
`timescale 1ns/100ps
interface fspmc_unlock_if;
  logic cmd_wr;
  logic prot_wr;
  logic other_acc;
  logic int_ack;
  logic accept;
  logic refuse;
  modport mgr (output cmd_wr, output prot_wr, output other_acc, output int_ack,
    input accept, input refuse);
  modport guard (input cmd_wr, input prot_wr, input other_acc, input int_ack,
    output accept, output refuse);
endinterface

// *** src/fspmc_unlock.sv ***
// Purpose: Arms one protected write after a command-register write.
// Assumes: Events are one-cycle pulses in the APB access phase.
// Notes: The verdict is combinational so the write lands in the same cycle.
`timescale 1ns/100ps
`include "fspmc_params.svh"
module fspmc_unlock (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  fspmc_unlock_if.guard ul
);
  logic armed;
  logic next_armed;

  // A protected write passes only while armed and no interrupt is taken.
  // R18 single armed write
  assign ul.accept = armed & ul.prot_wr & ~ul.int_ack;
  // R9 interrupt drops write
  assign ul.refuse = ul.prot_wr & ~ul.accept;

  // Any access or accepted interrupt other than the arming write disarms.
  assign next_armed = ul.cmd_wr ? 1'b1 :
    ((ul.prot_wr | ul.other_acc | ul.int_ack) ? 1'b0 : armed);

  // Holds the armed state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (ce) begin
      armed <= next_armed;
    end
  end
endmodule

// *** verif/fspmc_top_properties.sv ***
// Purpose: Port-level properties of the mode-control block.
// Assumes: One pclk domain; presetn is asynchronous and active low.
// Notes: Checks pause while ce is low, because ce freezes every state.
`timescale 1ns/100ps
module fspmc_top_properties #(
  parameter int SETTLE_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic vpp_pin,
  input wire logic trap_req,
  input wire logic [4:0] trap_vec,
  input wire logic fw_done,
  input wire logic fw_enter,
  input wire logic fw_running,
  input wire logic app_trap,
  input wire logic [4:0] app_trap_vec,
  input wire logic nmi_req,
  input wire logic flash_write_enable,
  input wire logic flash_access_ok
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn || !ce);

  // Counts blocked cycles since flash access was last allowed or writing last enabled, so the count starts at an exit made with writing enabled.
  int low_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 0;
    end else if (flash_access_ok || flash_write_enable) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end

  // Handoff lasts three more cycles, then the firmware runs.
  sequence s_handoff;
    !fw_running [*3] ##1 fw_running;
  endsequence

  a_handoff_to_run: assert property (fw_enter |=> s_handoff)
    else $error("handoff did not reach run on time");
  a_app_trap_route: assert property (trap_req && trap_vec != 5'h1F |=>
    app_trap && app_trap_vec == $past(trap_vec))
    else $error("trap not routed to application");
  a_fw_enter_cause: assert property (fw_enter |->
    $past(trap_req) && $past(trap_vec) == 5'h1F && !app_trap)
    else $error("firmware entered without its trap");
  a_handoff_nmi_lost: assert property (fw_enter |=> !nmi_req [*4])
    else $error("nmi forwarded during handoff");
  a_run_keeps_nmi: assert property (nmi_req |-> !$past(fw_running))
    else $error("nmi forwarded while firmware ran");
  a_done_ends_run: assert property (fw_running && fw_done |=> !fw_running)
    else $error("firmware return not honoured");
  a_write_needs_vpp: assert property (flash_write_enable |-> $past(vpp_pin, 2))
    else $error("flash write enabled without voltage");
  a_settle_wait: assert property ($rose(flash_access_ok) |-> low_cnt >= SETTLE_CYC)
    else $error("flash access allowed before settle time");
endmodule

bind fspmc_top fspmc_top_properties #(.SETTLE_CYC(SETTLE_CYC)) u_props (
  .pclk, .presetn, .ce, .vpp_pin, .trap_req, .trap_vec, .fw_done, .fw_enter,
  .fw_running, .app_trap, .app_trap_vec, .nmi_req, .flash_write_enable, .flash_access_ok
);

// *** verif/fspmc_top_test.sv ***
// Purpose: Register and trap sequences for the mode-control block.
// Assumes: Zero-wait APB; settle count shortened to 20 cycles.
// Notes: Every path ends in stop_test.
`timescale 1ns/100ps
module fspmc_top_test;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic ce = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic vpp_pin = 1'h0;
  logic nmi_pin = 1'h0;
  logic int_accept = 1'h0;
  logic trap_req = 1'h0;
  logic [4:0] trap_vec = 5'h0;
  logic fw_done = 1'h0;
  logic [31:0] fw_result = 32'h0;
  logic [31:0] prdata, rd;
  logic [159:0] args;
  logic [4:0] atv;
  logic pready, pslverr, er, fw_enter, fw_running, app_trap, nmi_req, fwe, fok;
  int failures = 0;
  int check_count = 0;

  fspmc_top #(.SETTLE_CYC(20)) DUT (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .vpp_pin, .nmi_pin, .int_accept, .trap_req, .trap_vec,
    .fw_done, .fw_result, .fw_enter, .fw_running, .app_trap, .app_trap_vec(atv),
    .nmi_req, .fw_args(args), .flash_write_enable(fwe), .flash_access_ok(fok)
  );

  logic [31:0] rom_prd;
  fspmc_top #(.SETTLE_CYC(20), .FLASH_EQUIPPED(1'h0)) rom_dut (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata(rom_prd), .pready(), .pslverr(), .vpp_pin, .nmi_pin, .int_accept, .trap_req,
    .trap_vec, .fw_done, .fw_result, .fw_enter(), .fw_running(), .app_trap(),
    .app_trap_vec(), .nmi_req(), .fw_args(), .flash_write_enable(), .flash_access_ok()
  );

  // Clock of 5 ns period.
  always #2.5 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask

  // same data for unlock and mode write.
  task automatic pw(input logic [31:0] d);
    wr(32'h04, d);
    wr(32'h00, d);
    repeat (5) @(posedge pclk);
  endtask

  // Trap pulse; returns at the falling edge of the answer cycle.
  task automatic trap(input logic [4:0] v);
    trap_req <= 1'h1;
    trap_vec <= v;
    @(posedge pclk);
    trap_req <= 1'h0;
    @(negedge pclk);
  endtask

  task automatic ret_fw;
    fw_done <= 1'h1;
    @(posedge pclk);
    fw_done <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length.
  initial begin
    #20000;
    failures++;
    stop_test;
  end

  // Main sequence of register and trap scenarios.
  initial begin
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rdc(32'h00, 32'h08);
    chk(rom_prd, 32'h00);
    rdc(32'h04, 32'h00);
    wr(32'h00, 32'h00);
    rdc(32'h00, 32'h08);
    rdc(32'h08, 32'h01);
    wr(32'h08, 32'h01);
    wr(32'h04, 32'h00);
    rdc(32'h00, 32'h08);
    wr(32'h00, 32'h00);
    rdc(32'h08, 32'h01);
    wr(32'h08, 32'h01);
    wr(32'h04, 32'h00);
    int_accept <= 1'h1;
    @(posedge pclk);
    int_accept <= 1'h0;
    wr(32'h00, 32'h00);
    rdc(32'h08, 32'h01);
    rdc(32'h00, 32'h08);
    wr(32'h08, 32'h01);
    pw(32'h02);
    rdc(32'h00, 32'h00);
    vpp_pin <= 1'h1;
    pw(32'h0A);
    rdc(32'h00, 32'h0E);
    chk(rom_prd, 32'h00);
    chk(fwe, 1'h0);
    pw(32'h02);
    rdc(32'h00, 32'h06);
    chk(fwe, 1'h1);
    for (int i = 0; i < 5; i++) begin
      wr(32'h10 + 4 * i, 32'hC0 + i);
    end
    for (int i = 0; i < 5; i++) begin
      chk(args[32 * i +: 32], 32'hC0 + i);
    end
    trap(5'h03);
    chk({app_trap, fw_enter, atv}, {2'h2, 5'h03});
    @(posedge pclk);
    trap(5'h1F);
    chk({app_trap, fw_enter}, 2'h1);
    repeat (6) @(posedge pclk);
    chk(fw_running, 1'h1);
    nmi_pin <= 1'h1;
    repeat (6) @(posedge pclk);
    nmi_pin <= 1'h0;
    fw_result <= 32'h5A;
    ret_fw;
    rdc(32'h24, 32'h5A);
    rdc(32'h0C, 32'h80);
    wr(32'h0C, 32'h00);
    rdc(32'h0C, 32'h00);
    nmi_pin <= 1'h1;
    trap(5'h1F);
    repeat (6) @(posedge pclk);
    nmi_pin <= 1'h0;
    ret_fw;
    rdc(32'h0C, 32'h00);
    pw(32'h08);
    rdc(32'h00, 32'h0C);
    @(negedge pclk);
    chk(fok, 1'h0);
    repeat (25) @(posedge pclk);
    chk(fok, 1'h1);
    trap(5'h1F);
    chk({app_trap, fw_enter, atv}, {2'h2, 5'h1F});
    @(posedge pclk);
    nmi_pin <= 1'h1;
    repeat (8) begin
      @(negedge pclk);
      n += int'(nmi_req === 1'h1);
    end
    chk(32'(n), 32'h1);
    @(posedge pclk);
    nmi_pin <= 1'h0;
    rdc(32'h40, 32'h0);
    chk(er, 1'h1);
    stop_test;
  end
endmodule
